// ---- core/tcw_defines.vh ----
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH
// ****************************************************************
// Register map (word offsets, not byte addresses).
// ****************************************************************
`define TCW_REG_CTRL      4'h0
`define TCW_REG_COUNT     4'h1
`define TCW_REG_COMPARE   4'h2
`define TCW_REG_FLAGS     4'h3
`define TCW_REG_PORT      4'h4
// ****************************************************************
// Control register fields.
// ****************************************************************
`define TCW_CTRL_CS_LSB   0
`define TCW_CTRL_CS_MSB   2
`define TCW_CTRL_MODE_LSB 3
`define TCW_CTRL_MODE_MSB 4
`define TCW_CTRL_ACT_LSB  5
`define TCW_CTRL_ACT_MSB  6
`define TCW_CTRL_DBUF     7
`define TCW_CTRL_FORCE    8
// ****************************************************************
// Flag and port register fields.
// ****************************************************************
`define TCW_FLAG_MATCH    0
`define TCW_FLAG_WAVE     1
`define TCW_PORT_DATA     0
`define TCW_PORT_DIR      1
// ****************************************************************
// Modes, actions, prescale selects and reset values.
// ****************************************************************
`define TCW_MODE_NORMAL   2'h0
`define TCW_MODE_CTC      2'h2
`define TCW_MODE_FAST     2'h3
`define TCW_ACT_NONE      2'h0
`define TCW_ACT_TOGGLE    2'h1
`define TCW_ACT_CLEAR     2'h2
`define TCW_ACT_SET       2'h3
`define TCW_CS_STOP       3'h0
`define TCW_CS_DIV1       3'h1
`define TCW_CS_DIV8       3'h2
`define TCW_CS_DIV64      3'h3
`define TCW_CS_DIV256     3'h4
`define TCW_CS_DIV1024    3'h5
`define TCW_CTRL_RESET    9'h000
`define TCW_COUNT_BOTTOM  8'h00
`define TCW_COUNT_MAX     8'hff
`endif

// ---- core/tcw_prescale.v ----
`timescale 1ns/1ps
`include "tcw_defines.vh"
// ****************************************************************
// Prescaler: one-cycle tick at clk divided by 1, 8, 64, 256, 1024.
// ****************************************************************
module tcw_prescale (
    // Clock and reset
    input  wire       clk,
    input  wire       srst,
    // Select and tick
    input  wire [2:0] sel,
    output reg        tick
);
    reg  [9:0] div_r;
    reg        hit;

    // The divider runs free so a select change never stalls the tick.
    always @(posedge clk) begin
        if (srst) begin
            div_r <= 10'h000;
        end else begin
            div_r <= div_r + 10'h001;
        end
    end

    // Tick when the low bits of the divider wrap for the chosen ratio.
    always @* begin
        case (sel)
            `TCW_CS_DIV1:    hit = 1'b1;
            `TCW_CS_DIV8:    hit = (div_r[2:0] == 3'h7);
            `TCW_CS_DIV64:   hit = (div_r[5:0] == 6'h3f);
            `TCW_CS_DIV256:  hit = (div_r[7:0] == 8'hff);
            `TCW_CS_DIV1024: hit = (div_r == 10'h3ff);
            default:         hit = 1'b0;
        endcase
        tick = hit & ~srst;
    end
endmodule

// ---- core/tcw_wave.v ----
`timescale 1ns/1ps
`include "tcw_defines.vh"
// ****************************************************************
// Waveform bit: applies match, force and wrap actions.
// ****************************************************************
module tcw_wave (
    // Clock and reset
    input  wire       clk,
    input  wire       srst,
    // Control
    input  wire [1:0] mode,
    input  wire [1:0] action,
    // Events
    input  wire       match,
    input  wire       force_hit,
    input  wire       wrap,
    // Result
    output reg        wave_r
);
    reg wave_nxt;

    // Mode changes never touch the bit; only events do.
    always @* begin
        wave_nxt = wave_r;
        if (mode == `TCW_MODE_FAST) begin
            if (action[1] && match) begin
                wave_nxt = ~action[0];
            end else if (action[1] && wrap) begin
                wave_nxt = action[0];
            end
        end else if (match || force_hit) begin
            case (action)
                `TCW_ACT_TOGGLE: wave_nxt = ~wave_r;
                `TCW_ACT_CLEAR:  wave_nxt = 1'b0;
                `TCW_ACT_SET:    wave_nxt = 1'b1;
                default:         wave_nxt = wave_r;
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wave_r <= 1'b0;
        end else begin
            wave_r <= wave_nxt;
        end
    end
endmodule

// ---- core/tcw_timer.v ----
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "tcw_defines.vh"
module tcw_timer (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Interrupt vector acknowledge from the core
    input  wire        vec_ack,
    // Pin
    output reg         pin_out,
    output reg         pin_oe,
    // Status
    output reg         match_flag_out
);
    // ****************************************************************
    // State.
    // ****************************************************************
    reg  [8:0] ctrl_r;
    reg  [7:0] count_r;
    reg  [7:0] compare_r;
    reg  [7:0] compare_buf_r;
    reg        flag_r;
    reg        port_data_r;
    reg        port_dir_r;
    reg        block_r;
    reg        force_r;
    reg        done_r;
    wire       tick;
    wire       wave;
    wire [1:0] mode   = ctrl_r[`TCW_CTRL_MODE_MSB:`TCW_CTRL_MODE_LSB];
    wire [1:0] action = ctrl_r[`TCW_CTRL_ACT_MSB:`TCW_CTRL_ACT_LSB];
    wire       dbuf   = ctrl_r[`TCW_CTRL_DBUF];
    wire       fast   = (mode == `TCW_MODE_FAST);

    // Request is taken once, then waitrequest drops for one cycle.
    wire       req    = (avs_read | avs_write) & ~done_r;
    wire       wr     = avs_write & ~done_r;
    wire       wr_lo  = wr & avs_byteenable[0];
    wire       wr_hi  = wr & avs_byteenable[1];
    wire       wr_cnt = wr_lo & (avs_address == `TCW_REG_COUNT);
    wire       wr_cmp = wr_lo & (avs_address == `TCW_REG_COMPARE);

    // ****************************************************************
    // Counter events.
    // ****************************************************************
    wire       wrap   = tick & (count_r == `TCW_COUNT_MAX);
    wire       ctc    = (mode == `TCW_MODE_CTC);
    wire       eq     = (count_r == compare_r);
    // A match is only counted once per timer tick and never right after
    // a counter write, so a written count equal to compare is silent.
    wire       match  = tick & eq & ~block_r & ~wr_cnt;
    wire       force_hit = force_r & ~fast;

    tcw_prescale u_pre (
        .clk  (clk),
        .srst (srst),
        .sel  (ctrl_r[`TCW_CTRL_CS_MSB:`TCW_CTRL_CS_LSB]),
        .tick (tick)
    );

    tcw_wave u_wave (
        .clk       (clk),
        .srst      (srst),
        .mode      (mode),
        .action    (action),
        .match     (match),
        .force_hit (force_hit),
        .wrap      (wrap & fast),
        .wave_r    (wave)
    );

    // ****************************************************************
    // Bus handshake.
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= req;
        end
    end

    // ****************************************************************
    // Control, port and force strobe registers.
    // ****************************************************************
    // Action bits take effect on the next clock, not at a wrap.
    always @(posedge clk) begin
        if (srst) begin
            ctrl_r      <= `TCW_CTRL_RESET;
            port_data_r <= 1'b0;
            port_dir_r  <= 1'b0;
            force_r     <= 1'b0;
        end else begin
            force_r <= 1'b0;
            if (avs_address == `TCW_REG_CTRL) begin
                if (wr_lo) begin
                    ctrl_r[7:0] <= avs_writedata[7:0];
                end
                if (wr_hi) begin
                    force_r <= avs_writedata[`TCW_CTRL_FORCE];
                end
            end
            if (wr_lo && avs_address == `TCW_REG_PORT) begin
                port_data_r <= avs_writedata[`TCW_PORT_DATA];
                port_dir_r  <= avs_writedata[`TCW_PORT_DIR];
            end
        end
    end

    // ****************************************************************
    // Counter: software write has priority over counting.
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            count_r <= `TCW_COUNT_BOTTOM;
            block_r <= 1'b0;
        end else begin
            if (wr_cnt) begin
                count_r <= avs_writedata[7:0];
                block_r <= 1'b1;
            end else if (tick) begin
                block_r <= 1'b0;
                // The forced strobe never clears the counter.
                if (ctc && match) begin
                    count_r <= `TCW_COUNT_BOTTOM;
                end else begin
                    count_r <= count_r + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Compare value and its buffer.
    // ****************************************************************
    // With buffering, software sees only the buffer; the active value
    // moves at the wrap so a period is never cut short.
    always @(posedge clk) begin
        if (srst) begin
            compare_r     <= `TCW_COUNT_BOTTOM;
            compare_buf_r <= `TCW_COUNT_BOTTOM;
        end else begin
            if (wr_cmp) begin
                compare_buf_r <= avs_writedata[7:0];
                if (!dbuf) begin
                    compare_r <= avs_writedata[7:0];
                end
            end else if (!dbuf) begin
                compare_buf_r <= compare_r;
            end
            if (dbuf && wrap) begin
                compare_r <= compare_buf_r;
            end
        end
    end

    // ****************************************************************
    // Match flag: hardware set wins over clear.
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            flag_r <= 1'b0;
        end else if (match) begin
            flag_r <= 1'b1;
        end else if (vec_ack || (wr_lo && avs_address == `TCW_REG_FLAGS &&
                                 avs_writedata[`TCW_FLAG_MATCH])) begin
            flag_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin: waveform replaces port data when action is non-zero.
    // ****************************************************************
    // Compare at 00 gives a one-tick spike and ff a steady level, both
    // falling out of the match/wrap ordering.
    always @(posedge clk) begin
        if (srst) begin
            pin_out        <= 1'b0;
            pin_oe         <= 1'b0;
            match_flag_out <= 1'b0;
        end else begin
            pin_out <= (action != `TCW_ACT_NONE) ? wave : port_data_r;
            pin_oe  <= port_dir_r;
            match_flag_out <= flag_r;
        end
    end

    // ****************************************************************
    // Read data.
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            avs_readdata    <= 32'h00000000;
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~req;
            avs_readdata    <= 32'h00000000;
            if (avs_read && !done_r) begin
                case (avs_address)
                    `TCW_REG_CTRL:    avs_readdata[7:0] <= ctrl_r[7:0];
                    `TCW_REG_COUNT:   avs_readdata[7:0] <= count_r;
                    `TCW_REG_COMPARE: avs_readdata[7:0] <= compare_buf_r;
                    `TCW_REG_FLAGS:   avs_readdata[1:0] <= {wave, flag_r};
                    `TCW_REG_PORT:    avs_readdata[1:0] <=
                                          {port_dir_r, port_data_r};
                    default:          avs_readdata    <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ---- sim/tcw_timer_assertions.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the timer block.
// ****************************************************************
module tcw_timer_chk (
    // Clock and reset
    input logic        clk,
    input logic        srst,
    // Bus
    input logic [3:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0]  avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    // Core and pin
    input logic        vec_ack,
    input logic        pin_out,
    input logic        pin_oe,
    input logic        match_flag_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Helper terms; a flag clear may come from the core or from software.
    wire req    = avs_read | avs_write;
    wire port_w = avs_write & (avs_address == 4'h4);
    wire clr_c  = vec_ack | (avs_write & (avs_address == 4'h3)
                  & avs_writedata[0] & avs_byteenable[0]);
    wire rd_ack = avs_read & ~avs_waitrequest;
    // Bus answer timing, then per-rule relations.
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held over one cycle");
    wait_answer_a: assert property ($rose(req) |=> !avs_waitrequest)
        else $error("answer late");
    idle_wait_a: assert property (!req && !$past(req) |-> avs_waitrequest)
        else $error("answer without request");
    reset_clear_a: assert property ($fell(srst) |-> avs_waitrequest
        && !pin_out && !pin_oe && !match_flag_out)
        else $error("outputs not cleared by reset");
    oe_cause_a: assert property ($changed(pin_oe) |-> $past(port_w)
        || $past(port_w, 2))
        else $error("pin enable moved without port write");
    flag_clear_a: assert property ($fell(match_flag_out) |->
        $past(clr_c, 2) || $past(clr_c, 3))
        else $error("flag dropped without clear");
    unmapped_zero_a: assert property (rd_ack && avs_address > 4'h4
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    force_zero_a: assert property (rd_ack && avs_address == 4'h0
        |-> !avs_readdata[8])
        else $error("force strobe read back");
endmodule
bind tcw_timer tcw_timer_chk u_chk (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vec_ack(vec_ack),
    .pin_out(pin_out), .pin_oe(pin_oe), .match_flag_out(match_flag_out));

// ---- sim/tcw_pin_load.sv ----
`timescale 1ns/1ps
// ****************************************************************
// External load on the waveform pin, with a weak pull-down.
// ****************************************************************
module tcw_pin_load (
    // Pin from the block
    input  logic pin_out,
    input  logic pin_oe,
    // Level seen by the load
    output logic load_level
);
    // An undriven pin falls to the pull-down, never keeps the last level.
    assign load_level = pin_oe ? pin_out : 1'b0;
endmodule

// ---- sim/test_timer0_compare_fast_pwm.sv ----
`timescale 1ns/1ps
`include "tcw_defines.vh"
// ****************************************************************
// Self-checking bench for the timer block.
// ****************************************************************
module test_timer0_compare_fast_pwm;
    // Bench signals, driven just after the rising edge.
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        vec_ack = 1'b0;
    logic        pin_out;
    logic        pin_oe;
    logic        match_flag_out;
    logic        load_level;
    logic [31:0] q;
    int          mismatches = 0;
    int          compares = 0;
    int          cyc = 0;
    int          h2;
    int          h3;
    logic [1:0]  act_t [4] = '{2'h2, 2'h3, 2'h1, 2'h1};
    logic        exp_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    initial forever #20 clk = ~clk;

    tcw_timer DUT (.clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .vec_ack(vec_ack), .pin_out(pin_out), .pin_oe(pin_oe),
        .match_flag_out(match_flag_out));
    tcw_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe),
        .load_level(load_level));

    // One bus access; the request stands until waitrequest is seen low.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) mismatches++;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // High cycles on the load over two PWM periods.
    task automatic meas(output int h);
        h = 0;
        repeat (512) begin
            @(posedge clk);
            if (load_level === 1'b1) h++;
        end
    endtask

    function automatic logic [31:0] frc(input logic [1:0] a);
        return (32'h1 << `TCW_CTRL_FORCE) | (32'(a) << `TCW_CTRL_ACT_LSB);
    endfunction

    task automatic conclude;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, `TCW_REG_CTRL, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, `TCW_REG_FLAGS, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 4'h9, 32'h0);
        chk(q, 32'h0);
        // Forced compares with the timer stopped; pin enabled once set.
        bus(1'b1, `TCW_REG_CTRL, frc(2'h3));
        bus(1'b1, `TCW_REG_PORT, 32'h2);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TCW_REG_CTRL, frc(act_t[i]));
            bus(1'b0, `TCW_REG_FLAGS, 32'h0);
            chk(q, {30'h0, exp_t[i], 1'b0});
            chk(load_level, exp_t[i]);
        end
        bus(1'b0, `TCW_REG_COUNT, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `TCW_REG_PORT, 32'h0);
        repeat (2) @(posedge clk);
        chk(load_level, 1'b0);
        bus(1'b1, `TCW_REG_CTRL, 32'h18);
        bus(1'b0, `TCW_REG_FLAGS, 32'h0);
        chk(q, 32'h2);
        // Counter written equal to compare, then started: match blocked.
        bus(1'b1, `TCW_REG_CTRL, 32'h0);
        bus(1'b1, `TCW_REG_COMPARE, 32'h10);
        bus(1'b1, `TCW_REG_COUNT, 32'h10);
        bus(1'b1, `TCW_REG_CTRL, 32'h1);
        bus(1'b0, `TCW_REG_FLAGS, 32'h0);
        chk(q, 32'h2);
        repeat (300) @(posedge clk);
        bus(1'b0, `TCW_REG_FLAGS, 32'h0);
        chk(q, 32'h3);
        chk(match_flag_out, 1'b1);
        bus(1'b1, `TCW_REG_FLAGS, 32'h1);
        bus(1'b0, `TCW_REG_FLAGS, 32'h0);
        chk(q, 32'h2);
        chk(match_flag_out, 1'b0);
        repeat (300) @(posedge clk);
        bus(1'b1, `TCW_REG_CTRL, 32'h0);
        vec_ack <= 1'b1;
        @(posedge clk);
        vec_ack <= 1'b0;
        bus(1'b0, `TCW_REG_FLAGS, 32'h0);
        chk(q, 32'h2);
        // Fast PWM at divide by one, buffered compare; the counter is never
        // written here, so no match can be lost.
        bus(1'b1, `TCW_REG_PORT, 32'h2);
        bus(1'b1, `TCW_REG_COMPARE, 32'h40);
        bus(1'b1, `TCW_REG_CTRL, 32'hd9);
        repeat (300) @(posedge clk);
        meas(h2);
        bus(1'b1, `TCW_REG_CTRL, 32'hf9);
        repeat (300) @(posedge clk);
        meas(h3);
        chk(h2 + h3, 32'd512);
        // Set at match 40, cleared at wrap: high for counts 41..ff.
        chk(h2, 32'd382);
        bus(1'b1, `TCW_REG_COMPARE, 32'h80);
        bus(1'b0, `TCW_REG_COMPARE, 32'h0);
        chk(q, 32'h80);
        repeat (300) @(posedge clk);
        meas(h3);
        // Inverted at compare 80: high for counts 00..80, two periods.
        chk(h3, 32'd258);
        conclude();
    end
endmodule
